// *** design/fci_host.sv ***
`default_nettype none
// Host sequencer driving the flash command interface pins
module fci_host #(
  parameter int ABORT_CYC = fci_pkg::ABORT_CYC,
  parameter int WINDOW_CYC = fci_pkg::WINDOW_CYC,
  parameter int SUSPEND_CYC = fci_pkg::SUSPEND_CYC
) (
  input wire logic I_MCLK,
  input wire logic I_RESET,
  input wire logic i_req,
  input wire logic [2:0] i_op,
  input wire logic i_bypass,
  input wire logic [16:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_more,
  input wire logic [7:0] i_data_lines,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_rdata,
  output logic o_in_bypass,
  output logic o_chip_sel_n,
  output logic o_read_n,
  output logic o_write_n,
  output logic [16:0] o_address_lines,
  output logic [7:0] o_data_lines,
  output logic o_data_oe
);
  typedef enum {
    ST_IDLE, ST_ROM, ST_SETUP, ST_STROBE, ST_HOLD, ST_READ, ST_SAMPLE, ST_WAIT
  } fci_state_t;
  fci_state_t state;
  fci_state_t after_write;
  logic [4:0] idx;
  logic [16:0] rom_addr;
  logic [7:0] rom_data;
  logic rom_last;
  logic use_user;
  logic last_write;
  logic [2:0] op;
  logic [16:0] user_addr;
  logic [7:0] user_data;
  logic [15:0] wait_cnt;
  logic [7:0] din_meta;
  logic [7:0] din_sync;
  logic [7:0] next_sample;

  fci_seq_rom u_rom (
    .i_clk(I_MCLK),
    .i_idx(idx),
    .o_addr(rom_addr),
    .o_data(rom_data),
    .o_last(rom_last)
  );

  // Two-flop capture of the flash data pins
  always_ff @(posedge I_MCLK) begin
    din_meta <= i_data_lines;
    din_sync <= din_meta;
  end
  assign next_sample = din_sync;

  function automatic logic [4:0] first_idx(input logic [2:0] f_op, input logic f_byp);
    case (f_op)
      fci_pkg::OP_RESET: first_idx = f_byp ? 5'h17 : 5'h00;
      fci_pkg::OP_IDENT: first_idx = f_byp ? 5'h0c : 5'h03;
      fci_pkg::OP_PROGRAM: first_idx = f_byp ? 5'h0e : 5'h06;
      fci_pkg::OP_CHIP_ERASE: first_idx = 5'h0f;
      fci_pkg::OP_BLOCK_ERASE: first_idx = 5'h0f;
      fci_pkg::OP_SUSPEND: first_idx = 5'h15;
      fci_pkg::OP_RESUME: first_idx = 5'h16;
      default: first_idx = 5'h0c;
    endcase
  endfunction

  // Sequencer
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      state <= ST_IDLE;
      after_write <= ST_IDLE;
      idx <= 5'h00;
      op <= 3'h0;
      use_user <= 1'b0;
      last_write <= 1'b0;
      user_addr <= 17'h00000;
      user_data <= 8'h00;
      wait_cnt <= 16'h0000;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= 8'h00;
      o_in_bypass <= 1'b0;
      o_chip_sel_n <= 1'b1;
      o_read_n <= 1'b1;
      o_write_n <= 1'b1;
      o_address_lines <= 17'h00000;
      o_data_lines <= 8'h00;
      o_data_oe <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (i_req) begin
            o_busy <= 1'b1;
            op <= i_op;
            user_addr <= i_addr;
            user_data <= i_wdata;
            use_user <= 1'b0;
            if (i_op == fci_pkg::OP_READ) begin
              o_address_lines <= i_addr;
              state <= ST_READ;
            end else begin
              // Ident with bypass flag enters bypass when out, exits when in
              idx <= (i_op == fci_pkg::OP_IDENT && i_bypass && !o_in_bypass) ? 5'h09 :
                     first_idx(i_op, i_bypass);
              state <= ST_ROM;
            end
          end
        end
        ST_ROM: begin
          // Table read takes one cycle; ST_SETUP then picks table word or user word
          state <= ST_SETUP;
        end
        ST_SETUP: begin
          // Address and data settle a cycle before the strobes fall
          o_data_oe <= 1'b1;
          if (use_user) begin
            o_address_lines <= user_addr;
            o_data_lines <= user_data;
            last_write <= !(op == fci_pkg::OP_BLOCK_ERASE && i_more);
          end else if (idx == 5'h17) begin
            // Single reset write to any address; keeps bypass
            o_address_lines <= 17'h00000;
            o_data_lines <= fci_pkg::CMD_RESET;
            last_write <= 1'b1;
          end else begin
            // Unlock addresses only matter in the low eleven bits
            o_address_lines <= rom_addr;
            o_data_lines <= rom_data;
            last_write <= rom_last && !(op == fci_pkg::OP_PROGRAM ||
                                        op == fci_pkg::OP_BLOCK_ERASE);
          end
          if (!use_user && op == fci_pkg::OP_BLOCK_ERASE && idx == 5'h13) begin
            last_write <= 1'b0;
          end
          if (!use_user && op == fci_pkg::OP_CHIP_ERASE && idx == 5'h13) begin
            last_write <= 1'b0;
          end
          state <= ST_STROBE;
        end
        ST_STROBE: begin
          // Address already stable when both strobes fall
          o_read_n <= 1'b1;
          o_chip_sel_n <= 1'b0;
          o_write_n <= 1'b0;
          state <= ST_HOLD;
        end
        ST_HOLD: begin
          // Strobes rise together, data held through the rise
          o_write_n <= 1'b1;
          o_chip_sel_n <= 1'b1;
          if (last_write) begin
            state <= ST_WAIT;
            after_write <= ST_IDLE;
            if (op == fci_pkg::OP_RESET) begin
              wait_cnt <= 16'(ABORT_CYC);
              o_in_bypass <= i_bypass;
            end else if (op == fci_pkg::OP_BLOCK_ERASE) begin
              wait_cnt <= 16'(WINDOW_CYC);
            end else if (op == fci_pkg::OP_SUSPEND) begin
              wait_cnt <= 16'(SUSPEND_CYC);
            end else begin
              wait_cnt <= 16'h0001;
            end
            if (op == fci_pkg::OP_IDENT && idx == 5'h05) begin
              o_in_bypass <= 1'b0;
            end
            if (idx == 5'h0b) begin
              o_in_bypass <= 1'b1;
            end
            if (idx == 5'h0d) begin
              o_in_bypass <= 1'b0;
            end
          end else begin
            state <= ST_SETUP;
            if (rom_last || op == fci_pkg::OP_BLOCK_ERASE && idx == 5'h13) begin
              use_user <= 1'b1;
            end else if (idx == 5'h13 && op == fci_pkg::OP_CHIP_ERASE) begin
              idx <= 5'h14;
              state <= ST_ROM;
            end else if (!use_user) begin
              idx <= idx + 5'h01;
              state <= ST_ROM;
            end
            if (use_user) begin
              // Another block address follows the 30 write
              user_addr <= i_addr;
              user_data <= fci_pkg::CMD_BLOCK_ERASE;
            end else if (op == fci_pkg::OP_BLOCK_ERASE && idx == 5'h13) begin
              user_data <= fci_pkg::CMD_BLOCK_ERASE;
            end
          end
        end
        ST_READ: begin
          // Read decode: select and read strobe low, write high
          o_data_oe <= 1'b0;
          o_chip_sel_n <= 1'b0;
          o_read_n <= 1'b0;
          o_write_n <= 1'b1;
          wait_cnt <= 16'h0003;
          state <= ST_SAMPLE;
        end
        ST_SAMPLE: begin
          // Status is polled by plain reads while busy; ident reads use A1:A0
          if (wait_cnt == 16'h0000) begin
            o_rdata <= next_sample;
            o_chip_sel_n <= 1'b1;
            o_read_n <= 1'b1;
            o_busy <= 1'b0;
            o_done <= 1'b1;
            state <= ST_IDLE;
          end else begin
            wait_cnt <= wait_cnt - 16'h0001;
          end
        end
        ST_WAIT: begin
          o_data_oe <= 1'b0;
          if (wait_cnt <= 16'h0001) begin
            o_busy <= 1'b0;
            o_done <= 1'b1;
            state <= after_write;
          end else begin
            wait_cnt <= wait_cnt - 16'h0001;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** design/fci_pkg.sv ***
`default_nettype none
package fci_pkg;
  localparam logic [16:0] ADDR_UNLOCK1 = 17'h00555;
  localparam logic [16:0] ADDR_UNLOCK2 = 17'h002aa;
  localparam logic [7:0] DATA_UNLOCK1 = 8'haa;
  localparam logic [7:0] DATA_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_BYPASS_EXIT = 8'h00;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam int BLOCK_LSB = 14;
  localparam int CLK_MHZ = 10;
  localparam int ABORT_US = 10;
  localparam int ABORT_CYC = ABORT_US * CLK_MHZ;
  localparam int WINDOW_US = 50;
  localparam int WINDOW_CYC = WINDOW_US * CLK_MHZ;
  localparam int SUSPEND_US = 15;
  localparam int SUSPEND_CYC = SUSPEND_US * CLK_MHZ;
  localparam int BUS_PHASE_CYC = 1;
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_RESET = 3'h1;
  localparam logic [2:0] OP_IDENT = 3'h2;
  localparam logic [2:0] OP_PROGRAM = 3'h3;
  localparam logic [2:0] OP_CHIP_ERASE = 3'h4;
  localparam logic [2:0] OP_BLOCK_ERASE = 3'h5;
  localparam logic [2:0] OP_SUSPEND = 3'h6;
  localparam logic [2:0] OP_RESUME = 3'h7;
endpackage
`default_nettype wire

// *** design/fci_seq_rom.sv ***
`default_nettype none
// Write sequence table: index -> {address, data, last flag}
module fci_seq_rom (
  input wire logic i_clk,
  input wire logic [4:0] i_idx,
  output logic [16:0] o_addr,
  output logic [7:0] o_data,
  output logic o_last
);
  logic [25:0] word;
  always_comb begin
    case (i_idx)
      5'h00: word = {fci_pkg::ADDR_UNLOCK1, fci_pkg::DATA_UNLOCK1, 1'b0};
      5'h01: word = {fci_pkg::ADDR_UNLOCK2, fci_pkg::DATA_UNLOCK2, 1'b0};
      5'h02: word = {17'h00000, fci_pkg::CMD_RESET, 1'b1};
      5'h03: word = {fci_pkg::ADDR_UNLOCK1, fci_pkg::DATA_UNLOCK1, 1'b0};
      5'h04: word = {fci_pkg::ADDR_UNLOCK2, fci_pkg::DATA_UNLOCK2, 1'b0};
      5'h05: word = {fci_pkg::ADDR_UNLOCK1, fci_pkg::CMD_IDENT, 1'b1};
      5'h06: word = {fci_pkg::ADDR_UNLOCK1, fci_pkg::DATA_UNLOCK1, 1'b0};
      5'h07: word = {fci_pkg::ADDR_UNLOCK2, fci_pkg::DATA_UNLOCK2, 1'b0};
      5'h08: word = {fci_pkg::ADDR_UNLOCK1, fci_pkg::CMD_PROGRAM, 1'b1};
      5'h09: word = {fci_pkg::ADDR_UNLOCK1, fci_pkg::DATA_UNLOCK1, 1'b0};
      5'h0a: word = {fci_pkg::ADDR_UNLOCK2, fci_pkg::DATA_UNLOCK2, 1'b0};
      5'h0b: word = {fci_pkg::ADDR_UNLOCK1, fci_pkg::CMD_BYPASS, 1'b1};
      5'h0c: word = {17'h00000, fci_pkg::CMD_IDENT, 1'b0};
      5'h0d: word = {17'h00000, fci_pkg::CMD_BYPASS_EXIT, 1'b1};
      5'h0e: word = {17'h00000, fci_pkg::CMD_PROGRAM, 1'b1};
      5'h0f: word = {fci_pkg::ADDR_UNLOCK1, fci_pkg::DATA_UNLOCK1, 1'b0};
      5'h10: word = {fci_pkg::ADDR_UNLOCK2, fci_pkg::DATA_UNLOCK2, 1'b0};
      5'h11: word = {fci_pkg::ADDR_UNLOCK1, fci_pkg::CMD_ERASE_SETUP, 1'b0};
      5'h12: word = {fci_pkg::ADDR_UNLOCK1, fci_pkg::DATA_UNLOCK1, 1'b0};
      5'h13: word = {fci_pkg::ADDR_UNLOCK2, fci_pkg::DATA_UNLOCK2, 1'b0};
      5'h14: word = {fci_pkg::ADDR_UNLOCK1, fci_pkg::CMD_CHIP_ERASE, 1'b1};
      5'h15: word = {17'h00000, fci_pkg::CMD_SUSPEND, 1'b1};
      5'h16: word = {17'h00000, fci_pkg::CMD_RESUME, 1'b1};
      default: word = {17'h00000, fci_pkg::CMD_RESET, 1'b1};
    endcase
  end
  always_ff @(posedge i_clk) begin
    o_addr <= word[25:9];
    o_data <= word[8:1];
    o_last <= word[0];
  end
endmodule
`default_nettype wire

// *** verif/fci_flash_model.sv ***
`default_nettype none
// Behavioural flash device on the far side of the host pins
module fci_flash_model #(
  parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] PART_ID = 8'hc3, // Arbitrary value
  parameter logic [7:0] PROT = 8'h04,
  parameter logic [7:0] STATUS = 8'h00, // Arbitrary busy status value
  parameter int BUSY_NS = 150
) (
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_we_n,
  input wire logic [16:0] i_a,
  input wire logic [7:0] i_d,
  output logic [7:0] o_d
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:131071];
  logic [16:0] wa;
  logic [7:0] last, rv;
  logic ident, armed, pend, blk, byp, bx, busy;
  logic [1:0] unl;
  int n_blk;
  wire wr = !i_cs_n && !i_we_n && i_rd_n;
  wire rd = !i_cs_n && !i_rd_n && i_we_n;
  task automatic ers(input logic [2:0] b);
    if (!PROT[b]) for (int i = 0; i < 16384; i++) mem[{b, i[13:0]}] = 8'hff;
  endtask
  initial begin
    for (int i = 0; i < 131072; i++) mem[i] = i[7:0] ^ 8'h3c;
    {ident, armed, pend, blk, byp, bx, busy, unl, last} = '0;
    n_blk = 0;
  end
  always @(posedge wr) wa = i_a;
  always @(negedge wr) begin
    automatic logic v = (unl == 2'd2);
    automatic logic u = v && (wa[10:0] == 11'h555);
    unl = (i_d == 8'haa && wa[10:0] == 11'h555) ? 2'd1 :
      (unl == 2'd1 && i_d == 8'h55 && wa[10:0] == 11'h2aa) ? 2'd2 : 2'd0;
    if (i_d == 8'hf0) begin
      busy = blk;
      busy <= #BUSY_NS 1'b0;
      {ident, pend, blk, armed} = '0;
    end else if (pend) begin
      if (!PROT[wa[16:14]]) begin
        mem[wa] = mem[wa] & i_d;
        busy = 1'b1;
        busy <= #BUSY_NS 1'b0;
      end
      pend = 0;
    end else if (byp && bx) {byp, bx} = {i_d != 8'h00, 1'b0};
    else if (byp) {pend, bx} = {i_d == 8'ha0, i_d == 8'h90};
    else if (blk && i_d == 8'h30) begin
      ers(wa[16:14]);
      n_blk++;
    end else if (u && i_d == 8'h90) ident = 1;
    else if (u && i_d == 8'ha0) pend = 1;
    else if (u && i_d == 8'h80) armed = 1;
    else if (u && i_d == 8'h20) byp = 1;
    else if (armed && u && i_d == 8'h10) begin
      for (int b = 0; b < 8; b++) ers(b[2:0]);
      armed = 0;
    end else if (armed && v && i_d == 8'h30) begin
      ers(wa[16:14]);
      {blk, armed} = 2'b10;
      n_blk++;
    end else if (i_d != 8'haa && i_d != 8'h55) {ident, armed, blk} = '0;
  end
  always @* rv = busy ? STATUS : !ident ? mem[i_a] :
    i_a[1] ? {7'h00, PROT[i_a[16:14]]} : i_a[0] ? PART_ID : MAKER_ID;
  always @(rv or rd) if (rd) last = rv;
  assign o_d = rd ? rv : ~last;
endmodule
`default_nettype wire

// *** verif/fci_host_assertions.sv ***
`default_nettype none
// Pin-level checks on the host sequencer
module fci_host_checker (
  input wire logic I_MCLK,
  input wire logic I_RESET,
  input wire logic i_req,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_chip_sel_n,
  input wire logic o_read_n,
  input wire logic o_write_n,
  input wire logic [16:0] o_address_lines,
  input wire logic [7:0] o_data_lines,
  input wire logic o_data_oe
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RESET);
  a_reset_idle: assert property ($fell(I_RESET) |-> o_chip_sel_n && o_read_n && o_write_n
    && !o_data_oe && !o_busy) else $error("Pins not idle after reset");
  a_no_contend: assert property (!(!o_read_n && !o_write_n))
    else $error("Read and write strobes low together");
  a_write_drives: assert property (!o_write_n |-> o_data_oe && !o_chip_sel_n)
    else $error("Write strobe without drive or select");
  a_read_floats: assert property (!o_read_n |-> !o_data_oe && !o_chip_sel_n)
    else $error("Read strobe while driving or deselected");
  a_strobe_pulse: assert property (!o_write_n |=> o_write_n)
    else $error("Write strobe longer than one cycle");
  a_data_hold: assert property ($rose(o_write_n) |-> $stable(o_address_lines)
    && $stable(o_data_lines)) else $error("Bus moved at write strobe rise");
  a_read_width: assert property ($fell(o_read_n) |-> !o_read_n [*3])
    else $error("Read strobe too short");
  a_done_idle: assert property (o_done |-> o_chip_sel_n && o_read_n && o_write_n)
    else $error("Strobes active at completion");
  a_done_pulse: assert property (o_done |=> !o_done)
    else $error("Done longer than one cycle");
  a_busy_start: assert property (!o_busy && i_req |=> o_busy)
    else $error("Request not taken");
  a_unlock_addr: assert property ($rose(o_write_n) && o_data_lines == 8'h55
    |-> o_address_lines[10:0] == 11'h2aa) else $error("Second unlock address wrong");
endmodule
bind fci_host fci_host_checker chk (.I_MCLK, .I_RESET, .i_req, .o_busy, .o_done,
  .o_chip_sel_n, .o_read_n, .o_write_n, .o_address_lines, .o_data_lines, .o_data_oe);
`default_nettype wire

// *** verif/fci_host_tb.sv ***
`default_nettype none
module fci_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic I_MCLK = 0, I_RESET = 1, req = 0, byp = 0, more = 0;
  logic [2:0] op = 0;
  logic [16:0] addr = 0;
  logic [7:0] wd = 0;
  wire logic busy, done, inb, cs_n, rd_n, we_n, oe;
  wire logic [16:0] al;
  wire logic [7:0] rdata, hd, fd, dl;
  int miscompares = 0, n_checks = 0;
  assign dl = oe ? hd : fd;
  always #50 I_MCLK = ~I_MCLK;
  fci_host #(.ABORT_CYC(2), .WINDOW_CYC(20), .SUSPEND_CYC(2)) uut (.I_MCLK(I_MCLK),
    .I_RESET(I_RESET), .i_req(req), .i_op(op), .i_bypass(byp), .i_addr(addr), .i_wdata(wd),
    .i_more(more), .i_data_lines(dl), .o_busy(busy), .o_done(done), .o_rdata(rdata),
    .o_in_bypass(inb), .o_chip_sel_n(cs_n), .o_read_n(rd_n), .o_write_n(we_n),
    .o_address_lines(al), .o_data_lines(hd), .o_data_oe(oe));
  fci_flash_model u_fl (.i_cs_n(cs_n), .i_rd_n(rd_n), .i_we_n(we_n), .i_a(al), .i_d(dl),
    .o_d(fd));
  function automatic logic [7:0] init_v(input logic [16:0] a);
    return a[7:0] ^ 8'h3c;
  endfunction
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wait_done;
    int n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(negedge I_MCLK);
      n++;
    end
    if (n >= 3000) begin
      miscompares++;
      $display("ERROR at %0t: expected %h got %h", $time, 1'b1, done);
    end
  endtask
  task automatic run(input logic [2:0] o, input logic [16:0] a, input logic [7:0] d);
    @(negedge I_MCLK);
    {op, addr, wd, req} = {o, a, d, 1'b1};
    @(negedge I_MCLK);
    req = 0;
    wait_done;
  endtask
  task automatic rd(input logic [16:0] a, input logic [7:0] exp);
    run(fci_pkg::OP_READ, a, 8'h00);
    chk(exp, rdata);
  endtask
  task automatic t_read;
    rd(17'h00123, init_v(17'h00123));
    rd(17'h1ffff, init_v(17'h1ffff));
  endtask
  task automatic t_program;
    run(fci_pkg::OP_PROGRAM, 17'h04010, 8'h0f);
    rd(17'h04010, init_v(17'h04010) & 8'h0f);
    run(fci_pkg::OP_PROGRAM, 17'h04010, 8'hf3);
    rd(17'h04010, init_v(17'h04010) & 8'h03);
    run(fci_pkg::OP_PROGRAM, 17'h08020, 8'h00);
    rd(17'h08020, init_v(17'h08020));
  endtask
  task automatic t_ident;
    run(fci_pkg::OP_IDENT, 17'h00000, 8'h00);
    rd(17'h1f37c, u_fl.MAKER_ID);
    rd(17'h1f37d, u_fl.PART_ID);
    rd(17'h0bffe, 8'h01);
    rd(17'h0c002, 8'h00);
    run(fci_pkg::OP_RESET, 17'h00000, 8'h00);
    rd(17'h00123, init_v(17'h00123));
  endtask
  task automatic t_block;
    int n = 0;
    @(negedge I_MCLK);
    {op, addr, more, req} = {fci_pkg::OP_BLOCK_ERASE, 17'h14000, 1'b1, 1'b1};
    @(negedge I_MCLK);
    {req, addr} = {1'b0, 17'h18000};
    while (u_fl.n_blk < 1 && n < 3000) begin
      @(negedge I_MCLK);
      n++;
    end
    more = 0;
    wait_done;
    rd(17'h14abc, 8'hff);
    rd(17'h18abc, 8'hff);
    rd(17'h1cabc, init_v(17'h1cabc));
    run(fci_pkg::OP_SUSPEND, 17'h00000, 8'h00);
    run(fci_pkg::OP_RESUME, 17'h00000, 8'h00);
    rd(17'h00124, init_v(17'h00124));
  endtask
  task automatic t_chip;
    run(fci_pkg::OP_CHIP_ERASE, 17'h00000, 8'h00);
    rd(17'h04010, 8'hff);
    rd(17'h08020, init_v(17'h08020));
  endtask
  task automatic t_bypass;
    byp = 1;
    run(fci_pkg::OP_IDENT, 17'h00000, 8'h00);
    chk(8'h01, {7'h00, inb});
    run(fci_pkg::OP_PROGRAM, 17'h0c123, 8'h0f);
    rd(17'h0c123, 8'h0f);
    run(fci_pkg::OP_RESET, 17'h00000, 8'h00);
    chk(8'h01, {7'h00, inb});
    run(fci_pkg::OP_PROGRAM, 17'h0c124, 8'h00);
    rd(17'h0c124, 8'h00);
    run(fci_pkg::OP_IDENT, 17'h00000, 8'h00);
    chk(8'h00, {7'h00, inb});
    byp = 0;
    run(fci_pkg::OP_IDENT, 17'h00000, 8'h00);
    rd(17'h00000, u_fl.MAKER_ID);
    run(fci_pkg::OP_RESET, 17'h00000, 8'h00);
  endtask
  initial begin
    #(100 * 40000);
    miscompares++;
    end_of_test;
  end
  initial begin
    repeat (8) @(negedge I_MCLK);
    I_RESET = 0;
    t_read;
    t_program;
    t_ident;
    t_block;
    t_chip;
    t_bypass;
    end_of_test;
  end
endmodule
`default_nettype wire
